//--- logic/ipc_consts.vh
// constants for the io port controller: key, field layout, reset values
// assumes a single 200 MHz system clock and no register bus
//
// How it works
// - non-debug pins start hi-z, paths off
// - each pin picks gpio or four peripherals
// - per pin pull-up, pull-down or none
// - per pin debounce filter enable
// - input enable low gates input path
// - filter runs only on port filter clock
// - key 0x0096 unlocks clock source and divider
// - any other key value relocks
// - 2-bit source, 4-bit divider select
// - source and divider set common sampling time
// - sleep-stop bit 0 keeps filtering in sleep
// - sleep-stop bit 1 stops filtering in sleep
// - gpio output drivers can be disabled
// - filter rejects pulses under sampling time
// - output data 1 drives high, 0 low
// - input data reads pin level
// - reset: pulls off, function gpio
`ifndef IPC_CONSTS_VH
`define IPC_CONSTS_VH
`define IPC_NPINS 8
`define IPC_KEY_UNLOCK 16'h0096
`define IPC_SRC_W 2
`define IPC_DIV_W 4
`define IPC_SRC_RST 2'h0
`define IPC_DIV_RST 4'h0
`define IPC_FUNC_GPIO 1'b0
`define IPC_FILT_STAGES 2
`endif

//--- logic/ipc_port.v
// io port controller: per-pin mux, enables, pulls and debounce filter
// assumes pins and peripheral inputs are asynchronous; clock sources
// are enabled by software; debug pins are handled elsewhere
`timescale 1ns/100ps
`include "ipc_consts.vh"

module ipc_port
(
    input wire i_clock,                 // 200 MHz system clock
    input wire i_rst_n,                 // synchronous reset, low
    input wire [3:0] i_src_tick,        // per-source clock ticks
    input wire [3:0] i_src_run,         // clock source running
    input wire [3:0] i_src_sleep_stop,  // sleep_stop_bit per source
    input wire i_sleep,                 // chip in sleep mode
    input wire i_key_we,                // protect_key_field write
    input wire [15:0] i_key_data,       // key written
    input wire i_clk_we,                // port clock config write
    input wire [1:0] i_clock_source_sel,// new clock source
    input wire [3:0] i_clock_div_sel,   // new divider select
    input wire [7:0] i_pin_input_enable,// per-pin input enable
    input wire [7:0] i_pin_output_enable,// per-pin output enable
    input wire [7:0] i_pull_enable,     // per-pin pull enable
    input wire [7:0] i_pull_up,         // 1 up, 0 down
    input wire [7:0] i_debounce_enable_bit, // per-pin filter enable
    input wire [7:0] i_periph_sel,      // 1 peripheral, 0 gpio
    input wire [15:0] i_func_sel,       // 2 bits per pin
    input wire [7:0] i_pin_out_data,    // gpio output data
    input wire [31:0] i_periph_out,     // 4 functions x 8 pins
    input wire [31:0] i_periph_oe,      // 4 functions x 8 pins
    input wire [7:0] i_pin,             // pin level in
    output wire [7:0] o_pin,            // pin drive level
    output wire [7:0] o_pin_oe,         // pin drive enable
    output wire [7:0] o_pull_up_en,     // pull-up resistor on
    output wire [7:0] o_pull_dn_en,     // pull-down resistor on
    output wire [7:0] o_pin_in_data,    // gpio input data
    output wire [31:0] o_periph_in,     // input to each function
    output wire o_locked,               // config write protected
    output wire [1:0] o_clock_source_sel, // current source
    output wire [3:0] o_clock_div_sel,  // current divider
    output wire o_filter_active         // filter clock usable
);

// ****************************************
// protection and clock configuration
// ****************************************
reg unlock_r;
reg [1:0] src_r;
reg [3:0] div_r;

always @(posedge i_clock)
begin
    if (!i_rst_n)
    begin
        unlock_r <= 1'b0;
        src_r <= `IPC_SRC_RST;
        div_r <= `IPC_DIV_RST;
    end
    else
    begin
        if (i_key_we)
            unlock_r <= (i_key_data == `IPC_KEY_UNLOCK);
        if (i_clk_we && unlock_r)
        begin
            src_r <= i_clock_source_sel;
            div_r <= i_clock_div_sel;
        end
    end
end

assign o_locked = ~unlock_r;
assign o_clock_source_sel = src_r;
assign o_clock_div_sel = div_r;

// ****************************************
// port filter clock: source tick / 2^div
// ****************************************
// software must start the source first; a stopped source never ticks
wire src_alive;
wire src_tick;
reg [15:0] div_cnt_r;
reg fclk_tick_r;
wire [15:0] div_limit;

assign src_alive = i_src_run[src_r] &
    ~(i_sleep & i_src_sleep_stop[src_r]);
assign src_tick = i_src_tick[src_r] & src_alive;
assign div_limit = (16'h0001 << div_r) - 16'h0001;

always @(posedge i_clock)
begin
    if (!i_rst_n)
    begin
        div_cnt_r <= 16'h0000;
        fclk_tick_r <= 1'b0;
    end
    else
    begin
        fclk_tick_r <= 1'b0;
        if (src_tick)
        begin
            if (div_cnt_r >= div_limit)
            begin
                div_cnt_r <= 16'h0000;
                fclk_tick_r <= 1'b1;
            end
            else
                div_cnt_r <= div_cnt_r + 16'h0001;
        end
    end
end

assign o_filter_active = src_alive;

// ****************************************
// one slice per pin
// ****************************************
// each slice owns its synchroniser, filter and mux; the function
// buses are regrouped so a slice sees only its own four functions
wire [31:0] periph_in_w;
genvar g;

generate
    for (g = 0; g < `IPC_NPINS; g = g + 1)
    begin : g_pin
        wire [3:0] fn_out;
        wire [3:0] fn_oe;
        wire [3:0] fn_in;

        assign fn_out = {i_periph_out[24+g], i_periph_out[16+g],
            i_periph_out[8+g], i_periph_out[g]};
        assign fn_oe = {i_periph_oe[24+g], i_periph_oe[16+g],
            i_periph_oe[8+g], i_periph_oe[g]};
        assign periph_in_w[g] = fn_in[0];
        assign periph_in_w[8+g] = fn_in[1];
        assign periph_in_w[16+g] = fn_in[2];
        assign periph_in_w[24+g] = fn_in[3];

        ipc_pin_slice u_slice
        (
            .i_clock(i_clock),
            .i_rst_n(i_rst_n),
            .i_fclk_tick(fclk_tick_r),
            .i_filter_ok(src_alive),
            .i_pin(i_pin[g]),
            .i_input_enable(i_pin_input_enable[g]),
            .i_output_enable(i_pin_output_enable[g]),
            .i_pull_enable(i_pull_enable[g]),
            .i_pull_up(i_pull_up[g]),
            .i_debounce_enable(i_debounce_enable_bit[g]),
            .i_periph_sel(i_periph_sel[g]),
            .i_func_sel(i_func_sel[2*g+1:2*g]),
            .i_out_data(i_pin_out_data[g]),
            .i_periph_out(fn_out),
            .i_periph_oe(fn_oe),
            .o_pin(o_pin[g]),
            .o_pin_oe(o_pin_oe[g]),
            .o_pull_up_en(o_pull_up_en[g]),
            .o_pull_dn_en(o_pull_dn_en[g]),
            .o_in_data(o_pin_in_data[g]),
            .o_periph_in(fn_in)
        );
    end
endgenerate

assign o_periph_in = periph_in_w;

endmodule

// ****************************************
// single pin slice
// ****************************************
// one pad: synchroniser, debounce filter, input gate, function mux
// and pull control; the filter tick comes from the shared divider
module ipc_pin_slice
(
    input wire i_clock,             // system clock
    input wire i_rst_n,             // synchronous reset, low
    input wire i_fclk_tick,         // port filter clock tick
    input wire i_filter_ok,         // filter clock usable
    input wire i_pin,               // pin level, asynchronous
    input wire i_input_enable,      // input path on
    input wire i_output_enable,     // gpio drive on
    input wire i_pull_enable,       // pull resistor wanted
    input wire i_pull_up,           // 1 up, 0 down
    input wire i_debounce_enable,   // filter on
    input wire i_periph_sel,        // 1 peripheral, 0 gpio
    input wire [1:0] i_func_sel,    // peripheral function
    input wire i_out_data,          // gpio output data
    input wire [3:0] i_periph_out,  // level per function
    input wire [3:0] i_periph_oe,   // enable per function
    output wire o_pin,              // drive level
    output wire o_pin_oe,           // drive enable
    output wire o_pull_up_en,       // pull-up on
    output wire o_pull_dn_en,       // pull-down on
    output wire o_in_data,          // registered input data
    output wire [3:0] o_periph_in   // input to chosen function
);

// ****************************************
// synchroniser
// ****************************************
reg sync1_r;
reg sync2_r;

always @(posedge i_clock)
begin
    if (!i_rst_n)
    begin
        sync1_r <= 1'b0;
        sync2_r <= 1'b0;
    end
    else
    begin
        sync1_r <= i_pin;
        sync2_r <= sync1_r;
    end
end

// ****************************************
// debounce filter
// ****************************************
// samples move only on filter ticks, so a level must hold over two
// ticks before it is accepted; shorter pulses never reach filt_r
reg samp_a_r;
reg samp_b_r;
reg filt_r;

always @(posedge i_clock)
begin
    if (!i_rst_n)
    begin
        samp_a_r <= 1'b0;
        samp_b_r <= 1'b0;
        filt_r <= 1'b0;
    end
    else if (i_fclk_tick)
    begin
        samp_a_r <= sync2_r;
        samp_b_r <= samp_a_r;
        if (samp_a_r == samp_b_r)
            filt_r <= samp_b_r;
    end
end

// ****************************************
// input data
// ****************************************
// a disabled input reads 0 so a floating pad causes no switching on in_r or the function inputs
reg in_r;
reg in_nxt;

always @*
begin
    in_nxt = sync2_r;
    if (!i_input_enable)
        in_nxt = 1'b0;
    else if (i_debounce_enable)
    begin
        if (i_filter_ok)
            in_nxt = filt_r;
        else
            in_nxt = 1'b0;
    end
end

always @(posedge i_clock)
begin
    if (!i_rst_n)
        in_r <= 1'b0;
    else
        in_r <= in_nxt;
end

// ****************************************
// function mux
// ****************************************
reg out_lvl;
reg out_en;
reg [3:0] to_periph;

always @*
begin
    out_lvl = i_out_data;
    out_en = i_output_enable;
    to_periph = 4'h0;
    if (i_periph_sel != `IPC_FUNC_GPIO)
    begin
        out_lvl = i_periph_out[i_func_sel];
        out_en = i_periph_oe[i_func_sel];
        to_periph[i_func_sel] = in_r;
    end
end

assign o_pin = out_lvl;
assign o_pin_oe = out_en;
assign o_periph_in = to_periph;
assign o_in_data = in_r;

// ****************************************
// pull control
// ****************************************
// pulls are forced off while driving, as a driven pin needs none
assign o_pull_up_en = i_pull_enable & i_pull_up & ~out_en;
assign o_pull_dn_en = i_pull_enable & ~i_pull_up & ~out_en;

endmodule

//--- tb/ipc_pin_model.sv
// pad model for the port pins: dut drive, far side drive, pulls
// assumes one clock; an undriven unpulled pad flips every cycle
`timescale 1ns/100ps
module ipc_pin_model
(
    input wire i_clock, // system clock
    input wire [7:0] i_drv, i_oe, // dut level and enable
    input wire [7:0] i_up, i_dn, // pulls on
    input wire [7:0] i_ext, i_ext_oe, // far side level and enable
    output reg [7:0] o_pad // resolved pad level
);
    reg [7:0] last_r = 8'h00;
    integer k;
    always @(posedge i_clock) last_r <= o_pad;
    // floating pad must not look like a stable level
    always @*
        for (k = 0; k < 8; k = k + 1)
            o_pad[k] = i_oe[k] ? i_drv[k] : i_ext_oe[k] ? i_ext[k] :
                i_up[k] | (~i_dn[k] & ~last_r[k]);
endmodule

//--- tb/ipc_port_checker.sv
// assertions on the ports of ipc_port
// assumes one clock domain and the synchronous low reset
`timescale 1ns/100ps
module ipc_port_checker
(
    input wire i_clock, i_rst_n, i_sleep, i_key_we, i_clk_we, // control
    input wire o_locked, o_filter_active, // status
    input wire [1:0] i_clock_source_sel, o_clock_source_sel, // source
    input wire [3:0] i_clock_div_sel, o_clock_div_sel, // divider
    input wire [3:0] i_src_run, i_src_sleep_stop, // per source
    input wire [15:0] i_key_data, // key
    input wire [7:0] i_pin_input_enable, i_debounce_enable_bit, i_pin, // in
    input wire [7:0] i_pull_enable, i_pull_up, o_pin_oe, // pull control
    input wire [7:0] o_pull_up_en, o_pull_dn_en, o_pin_in_data // outputs
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    sequence s_unlock;
        i_key_we && i_key_data == 16'h0096;
    endsequence
    sequence s_cfg;
        !o_locked && i_clk_we;
    endsequence
    a_key_unlock: assert property (s_unlock |=> !o_locked)
        else $error("unlock key ignored");
    a_key_relock: assert property
        (i_key_we && i_key_data != 16'h0096 |=> o_locked)
        else $error("other key left port unlocked");
    a_cfg_refused: assert property ((o_locked || !i_clk_we) |=>
        $stable(o_clock_source_sel) && $stable(o_clock_div_sel))
        else $error("clock config changed while locked");
    a_cfg_taken: assert property (s_unlock ##1 s_cfg |=>
        o_clock_source_sel == $past(i_clock_source_sel) &&
        o_clock_div_sel == $past(i_clock_div_sel))
        else $error("clock config not taken");
    a_in_gated: assert property (i_rst_n |=>
        (o_pin_in_data & ~$past(i_pin_input_enable)) == 8'h00)
        else $error("disabled input not gated");
    a_sync_path: assert property ((i_rst_n && i_pin_input_enable == 8'hff
        && i_debounce_enable_bit == 8'h00) [*4] |->
        o_pin_in_data == $past(i_pin, 3))
        else $error("input path delay wrong");
    a_pull_rule: assert property (1'b1 |->
        o_pull_up_en == (i_pull_enable & i_pull_up & ~o_pin_oe) &&
        o_pull_dn_en == (i_pull_enable & ~i_pull_up & ~o_pin_oe))
        else $error("pull enables wrong");
    a_filter_gate: assert property ((!i_src_run[o_clock_source_sel] ||
        (i_sleep && i_src_sleep_stop[o_clock_source_sel])) |->
        !o_filter_active)
        else $error("filter active without clock");
endmodule
bind ipc_port ipc_port_checker chk (.*);

//--- tb/test_ipc_port.sv
// self-checking bench for ipc_port: reset, then mux table, pulls,
// input path, key lock and filter cases; pads from ipc_pin_model
`timescale 1ns/100ps
module test_ipc_port;
    reg i_clock = 1'b0, i_rst_n = 1'b0, kwe = 1'b0, cwe = 1'b0, slp = 1'b0;
    reg [15:0] kd = 16'h0000, fs = 16'h0000;
    reg [1:0] cs = 2'h0;
    reg [3:0] cd = 4'h0, stop = 4'h0, run = 4'hf;
    reg [7:0] ie = 8'h00, oe = 8'h00, pe = 8'h00, pu = 8'h00, db = 8'h00;
    reg [7:0] ps = 8'h00, od = 8'h00, ext = 8'h00, xoe = 8'h00;
    wire [7:0] pad, pin, poe, up, dn, ind;
    wire lk, fa;
    wire [1:0] src;
    wire [3:0] dv;
    wire [31:0] pi;
    integer errors = 0, samples_checked = 0, n;
    reg [31:0] rows [0:5];
    always #2.5 i_clock = ~i_clock;
    ipc_port dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_src_tick(4'hf),
        .i_src_run(run), .i_src_sleep_stop(stop), .i_sleep(slp),
        .i_key_we(kwe), .i_key_data(kd), .i_clk_we(cwe),
        .i_clock_source_sel(cs), .i_clock_div_sel(cd),
        .i_pin_input_enable(ie), .i_pin_output_enable(oe),
        .i_pull_enable(pe), .i_pull_up(pu), .i_debounce_enable_bit(db),
        .i_periph_sel(ps), .i_func_sel(fs), .i_pin_out_data(od),
        .i_periph_out(32'h00000000), .i_periph_oe(32'h0f3355ff),
        .i_pin(pad), .o_pin(pin), .o_pin_oe(poe), .o_pull_up_en(up),
        .o_pull_dn_en(dn), .o_pin_in_data(ind), .o_periph_in(pi),
        .o_locked(lk), .o_clock_source_sel(src), .o_clock_div_sel(dv),
        .o_filter_active(fa));
    ipc_pin_model pm (.i_clock(i_clock), .i_drv(pin), .i_oe(poe),
        .i_up(up), .i_dn(dn), .i_ext(ext), .i_ext_oe(xoe), .o_pad(pad));
    task chk(input [31:0] seen, input [31:0] exp, input string nm);
    begin
        samples_checked = samples_checked + 1;
        if (seen !== exp)
        begin
            errors = errors + 1;
            $display("Error %0s exp %h seen %h", nm, exp, seen);
        end
    end
    endtask
    task key(input [15:0] v);
    begin
        kd = v;
        kwe = 1'b1;
        @(negedge i_clock) kwe = 1'b0;
    end
    endtask
    task summarize;
    begin
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask
    // ****
    // stimulus
    // ****
    initial
    begin
        rows[0] = 32'h00000081; rows[1] = 32'hff0000ff;
        rows[2] = 32'hff555555; rows[3] = 32'hffaaaa33;
        rows[4] = 32'hffffff0f; rows[5] = 32'hf0ffff01;
        repeat (3) @(negedge i_clock);
        i_rst_n = 1'b1;
        chk({lk, src, dv}, 32'h40, "reset cfg");
        chk({poe, up, dn, ind}, 32'h0, "reset pins");
        $display("reset done");
        oe = 8'h81;
        for (n = 0; n < 6; n = n + 1)
        begin
            @(negedge i_clock) {ps, fs} = rows[n][31:8];
            #1 chk(poe, rows[n][7:0], "mux oe");
        end
        ps = 8'h00; oe = 8'hff; od = 8'ha5; pe = 8'hff;
        #1 chk({pin, up, dn}, 32'ha50000, "gpio out");
        oe = 8'h00; pe = 8'h0f; pu = 8'h33;
        #1 chk({up, dn}, 32'h030c, "pulls");
        xoe = 8'hff; ext = 8'h5a; ie = 8'hff;
        repeat (4) @(negedge i_clock);
        chk(ind, 32'h5a, "input");
        ie = 8'h0f;
        repeat (2) @(negedge i_clock);
        chk(ind, 32'h0a, "gated");
        ps = 8'h02; fs = 16'h0008;
        #1 chk(pi, 32'h00020000, "periph in");
        ps = 8'h00;
        $display("pin tests done");
        cwe = 1'b1; cs = 2'h1; cd = 4'h1;
        key(16'h0095);
        cwe = 1'b0;
        chk({lk, src}, 32'h4, "refused");
        key(16'h0096);
        cwe = 1'b1;
        @(negedge i_clock) cwe = 1'b0;
        chk({lk, src, dv}, 32'h11, "unlocked");
        key(16'h0000);
        cwe = 1'b1; cs = 2'h2;
        @(negedge i_clock) cwe = 1'b0;
        chk({lk, src}, 32'h5, "relocked");
        ie = 8'h01; db = 8'h01; ext = 8'h00;
        repeat (8) @(negedge i_clock);
        ext = 8'h01;
        @(negedge i_clock) ext = 8'h00;
        repeat (10) @(negedge i_clock);
        chk(ind, 32'h0, "glitch");
        ext = 8'h01;
        for (n = 0; n < 40 && ind[0] !== 1'b1; n = n + 1) @(negedge i_clock);
        chk(ind, 32'h1, "filtered");
        if (n == 40) summarize;
        slp = 1'b1; stop = 4'h2;
        #1 chk(fa, 32'h0, "sleep stop");
        repeat (3) @(negedge i_clock);
        chk(ind, 32'h0, "stopped in");
        stop = 4'h0;
        #1 chk(fa, 32'h1, "sleep run");
        run = 4'hd;
        #1 chk(fa, 32'h0, "no source");
        i_rst_n = 1'b0;
        @(negedge i_clock) i_rst_n = 1'b1;
        chk({lk, src, dv}, 32'h40, "mid reset");
        $display("clock tests done");
        summarize;
    end
endmodule
